// file: tb/xzw_bridge_monitor.sv
`timescale 1ns/100ps
module xzw_bridge_monitor
   import xzw_pkg::*;
#(
   parameter int NPIN = 10
) (
   // clock and reset
   input wire logic CLK,
   input wire logic RST,
   // zero wait
   input wire logic ACC_ACTIVE,
   input wire logic [1:0] ACC_TARGET,
   input wire logic ZERO_WAIT_OUT_O,
   input wire logic ZERO_WAIT_OUT_OE,
   // shared pins
   input wire logic [NPIN-1:0] PIN_I,
   input wire logic [NPIN-1:0] PIN_OE,
   input wire logic [NPIN-1:0] ALT_OE,
   input wire logic [NPIN-1:0] ALT_I,
   input wire logic [7:0] XBUF_RDATA,
   input wire logic XBUF_RVALID
);
   // ==========
   // checks: four steady cycles flush the sync and output flops
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   AST_OD: assert property (!ZERO_WAIT_OUT_O)
      else $error("zero wait pin high");
   AST_IDLE: assert property (!ACC_ACTIVE [*4] |=> !ZERO_WAIT_OUT_OE)
      else $error("zero wait while idle");
   AST_NONE: assert property ((ACC_TARGET == TGT_NONE) [*4] |=> !ZERO_WAIT_OUT_OE)
      else $error("zero wait on no target");
   AST_CFG: assert property ((ACC_ACTIVE && ACC_TARGET == TGT_CONFIG) [*4] |=>
      !ZERO_WAIT_OUT_OE) else $error("zero wait on config");
   AST_DESEL: assert property (PIN_I[0] [*4] |=>
      PIN_OE[9:2] == 8'h00 || PIN_OE == $past(ALT_OE)) else $error("drive unselected");
   AST_RDIR: assert property (XBUF_RVALID |-> PIN_OE[9:2] == 8'h00)
      else $error("capture while driving");
   AST_RMODE: assert property (XBUF_RVALID |-> &ALT_I)
      else $error("capture in alternate mode");
   AST_BLOCK: assert property (!(&ALT_I) |-> XBUF_RDATA == 8'hff && !XBUF_RVALID)
      else $error("buffer input not blocked");
   cover property ($rose(ZERO_WAIT_OUT_OE));
   cover property (XBUF_RVALID);
   cover property (PIN_OE[9:2] == 8'hff);
endmodule
bind xzw_bridge xzw_bridge_monitor #(.NPIN(NPIN)) xzw_bridge_monitor_inst (.CLK(CLK),
   .RST(RST), .ACC_ACTIVE(ACC_ACTIVE), .ACC_TARGET(ACC_TARGET),
   .ZERO_WAIT_OUT_O(ZERO_WAIT_OUT_O), .ZERO_WAIT_OUT_OE(ZERO_WAIT_OUT_OE), .PIN_I(PIN_I),
   .PIN_OE(PIN_OE), .ALT_OE(ALT_OE), .ALT_I(ALT_I), .XBUF_RDATA(XBUF_RDATA),
   .XBUF_RVALID(XBUF_RVALID));

// file: tb/xzw_bridge_tb_top.sv
`timescale 1ns/100ps
module xzw_bridge_tb_top
   import xzw_pkg::*;
;
   logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, act = 1'b0, strap = 1'b1;
   logic [1:0] htrans = 2'h0, tgt = TGT_NONE, op = 2'h0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
   logic hready, hresp, zo, zoe, rv, sel_n, rd_n;
   logic [9:0] pin, po, poe, alt_o = '0, alt_oe = '0, alt_i;
   logic [7:0] hwd = 8'h00, wdat = 8'h00, xr, d_o;
   int error_cnt = 0, tests_run = 0, cyc = 0;
   // {expect, mode, ctl2 bit3, buffer_enable_strap bit0, target}
   logic [6:0] rows [9] = '{7'h3c, 7'h0d, 7'h2d, 7'h71, 7'h59, 7'h15, 7'h46, 7'h3a, 7'h3f};
   always #5 clk = ~clk;
   // ==========
   // wire level: design drive wins, else the peer
   assign pin = (poe & po) | (~poe & {d_o, rd_n, sel_n});
   xzw_bridge xzw_bridge_inst (.CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
      .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .ACC_ACTIVE(act), .ACC_TARGET(tgt),
      .ZERO_WAIT_OUT_O(zo), .ZERO_WAIT_OUT_OE(zoe), .BUFFER_ENABLE_STRAP(strap),
      .PIN_I(pin), .PIN_O(po), .PIN_OE(poe), .ALT_O(alt_o), .ALT_OE(alt_oe),
      .ALT_I(alt_i), .HOST_WDATA(hwd), .XBUF_RDATA(xr), .XBUF_RVALID(rv));
   xzw_xbus_peer xzw_xbus_peer_inst (.clk(clk), .op(op), .wdat(wdat), .sel_n(sel_n),
      .rd_n(rd_n), .d_o(d_o));
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         error_cnt++;
         $display("mismatch t=%0t seen %h exp %h", $time, s, e);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      q = hrdata;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         error_cnt++;
         wrap_up;
      end
   end
   initial begin
      tick(10);
      rst <= 1'b0;
      tick(1);
      bus(1'b0, OFF_CHIP_BUFFER_ENABLE_STRAP, 32'h0);
      chk(q, 32'h10);
      foreach (rows[i]) begin
         bus(1'b1, OFF_CHIP_BUFFER_ENABLE_STRAP, {27'h0, 1'b1, 3'h0, rows[i][2]});
         bus(1'b1, OFF_PP_CTL2, {28'h0, rows[i][3], 3'h0});
         bus(1'b1, OFF_PP_MODE, {30'h0, rows[i][5:4]});
         act <= 1'b1;
         tgt <= rows[i][1:0];
         tick(5);
         chk(zoe, rows[i][6]);
         chk(zo, 1'b0);
      end
      bus(1'b0, OFF_PP_MODE, 32'h0);
      chk(q, 32'h3);
      chk(hresp, 1'b0);
      bus(1'b0, OFF_STATUS, 32'h0);
      chk(q, 32'h3e);
      $display("zero wait test done");
      act <= 1'b0;
      op <= 2'h1;
      wdat <= 8'ha5;
      tick(5);
      chk(zoe, 1'b0);
      chk({poe, xr}, {10'h0, 8'ha5});
      chk(alt_i, 10'h3ff);
      chk(rv, 1'b1);
      op <= 2'h2;
      hwd <= 8'h3c;
      tick(5);
      chk({poe[9:2], po[9:2]}, 16'hff3c);
      chk(rv, 1'b0);
      op <= 2'h0;
      tick(5);
      chk(poe[9:2], 8'h0);
      $display("buffer test done");
      alt_o <= 10'h2a8;
      alt_oe <= 10'h3fc;
      bus(1'b1, OFF_CHIP_BUFFER_ENABLE_STRAP, 32'h0);
      tick(5);
      chk({poe, alt_i, xr}, {10'h3fc, 10'h2ab, 8'hff});
      strap <= 1'b0;
      rst <= 1'b1;
      tick(10);
      rst <= 1'b0;
      tick(1);
      bus(1'b0, OFF_CHIP_BUFFER_ENABLE_STRAP, 32'h0);
      chk(q, 32'h0);
      $display("alternate test done");
      wrap_up;
   end
endmodule

// file: tb/xzw_xbus_peer.sv
`timescale 1ns/100ps
module xzw_xbus_peer (
   // clock
   input wire logic clk,
   // command: 0 idle, 1 write to buffer, 2 read from buffer
   input wire logic [1:0] op,
   input wire logic [7:0] wdat,
   // pins
   output logic sel_n,
   output logic rd_n,
   output logic [7:0] d_o
);
   // ==========
   // released data shows the inverse so stale values cannot pass
   always_ff @(posedge clk) begin
      sel_n <= op == 2'h0;
      rd_n <= op != 2'h2;
      d_o <= op == 2'h1 ? wdat : ~wdat;
   end
endmodule

// file: verilog/xzw_bridge.sv
// Decided for this implementation: the register offsets and the AHB-Lite register port.
`timescale 1ns/100ps
module xzw_bridge
   import xzw_pkg::*;
#(
   parameter int NPIN = 10
) (
   // clock and reset
   input wire logic CLK,
   input wire logic RST,
   // ahb-lite slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   // host access classification (pins)
   input wire logic ACC_ACTIVE,
   input wire logic [1:0] ACC_TARGET,
   // zero-wait open-drain pin
   output logic ZERO_WAIT_OUT_O,
   output logic ZERO_WAIT_OUT_OE,
   // strap pin
   input wire logic BUFFER_ENABLE_STRAP,
   // shared pins: 0 select_n, 1 read_n, 2..9 data lines
   input wire logic [NPIN-1:0] PIN_I,
   output logic [NPIN-1:0] PIN_O,
   output logic [NPIN-1:0] PIN_OE,
   // alternate functions behind the shared pins
   input wire logic [NPIN-1:0] ALT_O,
   input wire logic [NPIN-1:0] ALT_OE,
   output logic [NPIN-1:0] ALT_I,
   // host side of the x-bus data buffer
   input wire logic [7:0] HOST_WDATA,
   output logic [7:0] XBUF_RDATA,
   output logic XBUF_RVALID
);

   // ==========================================
   // state
   typedef struct packed {
      logic [NPIN-1:0] pin_s1;
      logic [NPIN-1:0] pin_s2;
      logic strap_s1;
      logic strap_s2;
      logic acc_s1;
      logic acc_s2;
      logic [1:0] tgt_s1;
      logic [1:0] tgt_s2;
      xzw_regs_t regs;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [31:0] hrdata;
      logic zws_oe;
      logic [NPIN-1:0] pin_o;
      logic [NPIN-1:0] pin_oe;
      logic [NPIN-1:0] alt_i;
      logic [7:0] xbuf_rdata;
      logic xbuf_rvalid;
   } xzw_state_t;

   xzw_state_t s_r;
   xzw_state_t s_nxt;

   // ==========================================
   // timing overview
   // every pin input passes two flops before any decision, so the
   // zero-wait enable and the shared-pin drivers react three edges after
   // a pin moves: two for the synchroniser, one for the output flop.
   // a register write acts at the edge that ends its data phase, because the
   // decode reads the post-write copy of the registers.
   //
   // the host access class arrives as a level pair (active, target).
   // the pin is open-drain: the output value is fixed low and only the
   // enable moves, so a released pin is left to the board pull-up.
   // trade-off: the extra sync latency costs zero-wait margin on very
   // short host cycles, but a metastable target code could otherwise
   // pull the pin low on a configuration access.
   //
   // shared pins: in buffer mode the select and read command are taken
   // active low; the data lines are driven only while both are low, and
   // data is captured while selected with the read command high.
   // in alternate mode the alternate functions own every driver and the
   // buffer side reads inactive, its capture register parked at all ones.
   //
   // limitation: the host-side buffer data is not synchronised; it must
   // come from logic on this clock.
   //
   // the strap is resampled on every reset edge; only its value at the
   // last reset edge survives into the buffer enable bit.

   // ==========================================
   // functions
   // target decode is a pure function of the synced access class and the
   // current registers, so the status word can report the same answer
   // that the pin takes on at the same edge.
   function automatic logic zws_wanted(input logic act, input logic [1:0] tgt,
                                       input xzw_regs_t r);
      logic w;
      w = 1'b0;
      if (act) begin
         unique case (tgt)
            TGT_CONFIG: w = 1'b0;
            TGT_PPORT: begin
               unique case (r.pp_mode)
                  PP_ECP: w = 1'b1;
                  PP_EPP17: w = r.pport_second_control[CTL2_ZWS_BIT];
                  PP_SPP: w = 1'b0;
                  PP_EPP19: w = 1'b0;
               endcase
            end
            TGT_OTHER: w = r.chip_config_one[BUFFER_ENABLE_STRAP_ZWS_BIT];
            TGT_NONE: w = 1'b0;
         endcase
      end
      return w;
   endfunction

   function automatic logic [31:0] rd_mux(input logic [7:0] a, input xzw_state_t s,
                                          input logic zero_wait_out);
      logic [31:0] d;
      d = 32'h0000_0000;
      unique case (a)
         OFF_CHIP_BUFFER_ENABLE_STRAP: d = {24'h00_0000, s.regs.chip_config_one};
         OFF_PP_CTL2: d = {24'h00_0000, s.regs.pport_second_control};
         OFF_PP_MODE: d = {30'h0000_0000, s.regs.pp_mode};
         OFF_STATUS: d = {26'h000_0000, s.strap_s2,
                          s.regs.chip_config_one[BUFFER_ENABLE_STRAP_XDB_BIT],
                          s.tgt_s2, s.acc_s2, zero_wait_out};
         default: d = 32'h0000_0000;
      endcase
      return d;
   endfunction

   // ==========================================
   // next state
   always_comb begin
      logic xbus_data_buffer;
      logic sel;
      logic rd;
      logic addr_ok;
      logic zero_wait_out;
      logic [NPIN-1:0] pin_view;
      xbus_data_buffer = 1'b0;
      sel = 1'b0;
      rd = 1'b0;
      addr_ok = 1'b0;
      zero_wait_out = 1'b0;
      pin_view = '1;
      s_nxt = s_r;

      // two-flop synchronisers for every pin input
      s_nxt.pin_s1 = PIN_I;
      s_nxt.pin_s2 = s_r.pin_s1;
      s_nxt.strap_s1 = BUFFER_ENABLE_STRAP;
      s_nxt.strap_s2 = s_r.strap_s1;
      s_nxt.acc_s1 = ACC_ACTIVE;
      s_nxt.acc_s2 = s_r.acc_s1;
      s_nxt.tgt_s1 = ACC_TARGET;
      s_nxt.tgt_s2 = s_r.tgt_s1;

      if (RST) begin
         s_nxt.regs.chip_config_one = BUFFER_ENABLE_STRAP_RST;
         // strap is sampled every reset cycle; last value before release sticks
         s_nxt.regs.chip_config_one[BUFFER_ENABLE_STRAP_XDB_BIT] = s_r.strap_s2;
         s_nxt.regs.pport_second_control = CTL2_RST;
         s_nxt.regs.pp_mode = PP_MODE_RST;
         s_nxt.wr_pend = 1'b0;
         s_nxt.wr_addr = 8'h00;
         s_nxt.hrdata = 32'h0000_0000;
         s_nxt.zws_oe = 1'b0;
         s_nxt.pin_o = '0;
         s_nxt.pin_oe = '0;
         s_nxt.alt_i = '1;
         s_nxt.xbuf_rdata = 8'h00;
         s_nxt.xbuf_rvalid = 1'b0;
      end else begin
         // ---------------- register writes (data phase)
         if (s_r.wr_pend) begin
            unique case (s_r.wr_addr)
               OFF_CHIP_BUFFER_ENABLE_STRAP: s_nxt.regs.chip_config_one = HWDATA[7:0];
               OFF_PP_CTL2: s_nxt.regs.pport_second_control = HWDATA[7:0];
               OFF_PP_MODE: s_nxt.regs.pp_mode = HWDATA[1:0];
               default: ;
            endcase
         end

         // ---------------- address phase
         addr_ok = HSEL && HTRANS[1] && HREADY;
         s_nxt.wr_pend = addr_ok && HWRITE;
         s_nxt.wr_addr = HADDR[7:0];
         zero_wait_out = zws_wanted(s_r.acc_s2, s_r.tgt_s2, s_nxt.regs);
         // read mux looks at the post-write registers so a read right after
         // a write to the same word returns the new value
         if (addr_ok && !HWRITE) begin
            s_nxt.hrdata = rd_mux(HADDR[7:0], s_nxt, zero_wait_out);
         end

         // ---------------- zero-wait pin
         // only ever pulled low; otherwise released to the pull-up
         s_nxt.zws_oe = zero_wait_out;

         // ---------------- shared pin multiplexing
         xbus_data_buffer = s_nxt.regs.chip_config_one[BUFFER_ENABLE_STRAP_XDB_BIT];
         if (xbus_data_buffer) begin
            sel = !s_r.pin_s2[PIN_SEL];
            rd = !s_r.pin_s2[PIN_RD];
            s_nxt.alt_i = '1;
            s_nxt.pin_o = '0;
            s_nxt.pin_oe = '0;
            s_nxt.pin_o[PIN_D0 +: 8] = HOST_WDATA;
            s_nxt.pin_oe[PIN_D0 +: 8] = {8{sel && rd}};
            s_nxt.xbuf_rvalid = sel && !rd;
            if (sel && !rd) begin
               s_nxt.xbuf_rdata = s_r.pin_s2[PIN_D0 +: 8];
            end
         end else begin
            // buffer controls read inactive (high) while alternates own the pins
            pin_view = s_r.pin_s2;
            s_nxt.alt_i = pin_view;
            s_nxt.pin_o = ALT_O;
            s_nxt.pin_oe = ALT_OE;
            s_nxt.xbuf_rvalid = 1'b0;
            s_nxt.xbuf_rdata = 8'hff;
         end
      end
   end

   // ==========================================
   // registers
   // one flop bank for the whole state; reset is carried by the next-state
   // logic so every field but the two-flop synchronisers resets synchronously.
   always_ff @(posedge CLK) begin
      s_r <= s_nxt;
   end

   // ==========================================
   // outputs, straight from flops except the tied-off HREADYOUT, HRESP and ZERO_WAIT_OUT_O
   assign HRDATA = s_r.hrdata;
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;
   assign ZERO_WAIT_OUT_O = 1'b0;
   assign ZERO_WAIT_OUT_OE = s_r.zws_oe;
   assign PIN_O = s_r.pin_o;
   assign PIN_OE = s_r.pin_oe;
   assign ALT_I = s_r.alt_i;
   assign XBUF_RDATA = s_r.xbuf_rdata;
   assign XBUF_RVALID = s_r.xbuf_rvalid;

endmodule

// file: verilog/xzw_pkg.sv
package xzw_pkg;

   // ==========================================
   // register map (byte offsets)
   localparam logic [7:0] OFF_CHIP_BUFFER_ENABLE_STRAP = 8'h00;
   localparam logic [7:0] OFF_PP_CTL2 = 8'h04;
   localparam logic [7:0] OFF_PP_MODE = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0c;

   // ==========================================
   // field positions and reset values
   localparam int BUFFER_ENABLE_STRAP_ZWS_BIT = 0;
   localparam int BUFFER_ENABLE_STRAP_XDB_BIT = 4;
   localparam int CTL2_ZWS_BIT = 3;
   localparam logic [7:0] BUFFER_ENABLE_STRAP_RST = 8'h00;
   localparam logic [7:0] CTL2_RST = 8'h00;
   localparam logic [1:0] PP_MODE_RST = 2'h0;

   // ==========================================
   // parallel-port modes and access targets
   localparam logic [1:0] PP_SPP = 2'h0;
   localparam logic [1:0] PP_EPP17 = 2'h1;
   localparam logic [1:0] PP_EPP19 = 2'h2;
   localparam logic [1:0] PP_ECP = 2'h3;
   localparam logic [1:0] TGT_CONFIG = 2'h0;
   localparam logic [1:0] TGT_PPORT = 2'h1;
   localparam logic [1:0] TGT_OTHER = 2'h2;
   localparam logic [1:0] TGT_NONE = 2'h3;

   // ==========================================
   // shared pin layout
   localparam int PIN_SEL = 0;
   localparam int PIN_RD = 1;
   localparam int PIN_D0 = 2;

   typedef struct packed {
      logic [7:0] chip_config_one;
      logic [7:0] pport_second_control;
      logic [1:0] pp_mode;
   } xzw_regs_t;

endpackage
